// ### verilog/cbf_params.svh
`ifndef CBF_PARAMS_SVH
`define CBF_PARAMS_SVH
// register indices; byte address is four times the index
`define CBF_IDX_DATA0 6'h04
`define CBF_IDX_DATA7 6'h0B
`define CBF_IDX_LEN 6'h0C
`define CBF_IDX_LOCAL_PRIORITY_VALUE 6'h0D
`define CBF_IDX_STAMP_HI 6'h0E
`define CBF_IDX_STAMP_LO 6'h0F
`define CBF_IDX_SELECT 6'h10
`define CBF_IDX_TXFLAG 6'h11
`define CBF_IDX_CTRL 6'h12
`define CBF_IDX_REMOTE 6'h13
`define CBF_IDX_STATUS 6'h14
`define CBF_IDX_RX_BASE 6'h20
// field positions
`define CBF_LEN_CODE_MSB 3
`define CBF_CTRL_INIT_BIT 0
`define CBF_CTRL_TIME_BIT 1
`define CBF_STAT_ACTIVE_BIT 2
`define CBF_STAT_TIMER_LSB 16
// reset values and counts
`define CBF_NUM_TX 3
`define CBF_LOCAL_PRIORITY_VALUE_RST 8'h00
`define CBF_TXE_RST 3'h7
`define CBF_CTRL_RST 2'h1
`define CBF_MAX_BYTES 4'h8
`endif

// ### verilog/cbf_pkg.sv
package cbf_pkg;
   typedef enum logic [1:0] {
      CBF_IDLE = 2'b00,
      CBF_LOAD = 2'b01,
      CBF_WAIT = 2'b10
   } cbf_state_e;
   typedef logic [7:0] cbf_byte_t;
   typedef logic [1:0] cbf_idx_t;
   typedef logic [3:0] cbf_len_t;
   typedef logic [15:0] cbf_stamp_t;
endpackage : cbf_pkg

// ### verilog/cbf_buffers.sv
// Notes on behaviour
// R01 - each buffer holds eight payload bytes, bits 7..0 each
// R02 - bytes sent or stored come from the buffer's length code
// R03 - length code sits in bits 3..0 of the length register
// R04 - remote frame: length code sent as written, zero data bytes sent
// R05 - data frames carry anywhere from zero to eight bytes
// R06 - eight-bit local priority per transmit buffer; smaller value wins
// R07 - arbitration runs over pending buffers just before start of frame
// R08 - the pending buffer with the lowest priority value is chosen
// R09 - equal lowest priority: the smaller buffer index is chosen
// R10 - software writes priority only on an empty, selected buffer
// R11 - software reads stamps only on an empty, selected buffer (the code checks selection only, so a selected pending buffer still reads)
// R12 - with stamping on, timer copied into active buffer after valid frame end
// R13 - software takes a transmit stamp only after the buffer is empty again
// R14 - stamp timer is free running on the bit clock; wrap not signalled
// R15 - stamp timer held at zero during initialization mode
// R16 - stamp bytes are read-only; writes are ignored
// R17 - successful send sets that buffer's empty flag
// R18 - writing the select register maps that buffer into the window (the code maps only the lowest requested buffer that is empty)
// R19 - length codes above eight never move more than eight bytes
//
// Design decision made here: the AHB-Lite interface to the registers.
`include "cbf_params.svh"
module cbf_buffers (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // frame engine, transmit side
   input wire logic tx_sof_req,
   input wire logic tx_done,
   input wire logic tx_fail,
   output logic tx_frame_active,
   output cbf_pkg::cbf_idx_t tx_buf_idx,
   output cbf_pkg::cbf_len_t tx_len_code,
   output logic tx_remote,
   output cbf_pkg::cbf_byte_t tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   // frame engine, receive side
   input wire logic rx_sof,
   input wire cbf_pkg::cbf_len_t rx_len_code,
   input wire logic rx_byte_valid,
   input wire cbf_pkg::cbf_byte_t rx_byte,
   input wire logic rx_eof_ok,
   // bit clock tick
   input wire logic bit_tick
);
   import cbf_pkg::*;

   cbf_byte_t txb_r [`CBF_NUM_TX][8];
   cbf_len_t len_r [`CBF_NUM_TX];
   cbf_byte_t local_priority_value_r [`CBF_NUM_TX];
   cbf_stamp_t stamp_r [`CBF_NUM_TX];
   logic [`CBF_NUM_TX-1:0] txe_r, txe_nxt, sel_r, remote_r, done_set;
   logic [1:0] ctrl_r;
   cbf_byte_t rxb_r [8];
   cbf_len_t rx_len_r;
   cbf_stamp_t rx_stamp_r, timer_r;
   logic [3:0] rx_cnt_r;
   cbf_state_e state_r;
   cbf_idx_t act_r, win_idx, sel_idx;
   logic win_found;
   cbf_byte_t win_local_priority_value;
   logic [3:0] byte_cnt_r, byte_total_r, cap_len;
   logic init_mode, time_en;
   // ahb data-phase state
   logic wr_pend_r, rd_pend_r, addr_ok_r;
   logic [5:0] addr_idx_r;
   logic wr_en;
   logic [31:0] rd_data;
   // two-entry output buffer
   cbf_byte_t skid_r;
   logic skid_v_r, push, flush, in_ready, pop;

   assign init_mode = ctrl_r[`CBF_CTRL_INIT_BIT];
   assign time_en = ctrl_r[`CBF_CTRL_TIME_BIT];
   assign wr_en = wr_pend_r & addr_ok_r;

   // ---------------- bus slave ----------------
   // reads take one wait state so a write just before is always visible
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_ok_r <= 1'b0;
         addr_idx_r <= 6'h00;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
      end else begin
         if (rd_pend_r) begin
            hrdata <= rd_data;
            hreadyout <= 1'b1;
            rd_pend_r <= 1'b0;
         end else if (hsel && htrans[1] && hready) begin
            wr_pend_r <= hwrite;
            rd_pend_r <= !hwrite;
            hreadyout <= hwrite;
            addr_ok_r <= (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00) && (hsize == 3'b010);
            addr_idx_r <= haddr[7:2];
         end else begin
            wr_pend_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   always_comb begin
      sel_idx = 2'd0;
      for (int k = `CBF_NUM_TX - 1; k >= 0; k--) begin
         if (sel_r[k]) begin
            sel_idx = cbf_idx_t'(k);
         end
      end
   end

   always_comb begin
      logic [5:0] li;
      li = 6'h00;
      rd_data = 32'h0000_0000;
      if (addr_ok_r && addr_idx_r >= `CBF_IDX_RX_BASE) begin
         li = addr_idx_r - `CBF_IDX_RX_BASE;
         if (li >= `CBF_IDX_DATA0 && li <= `CBF_IDX_DATA7) begin
            rd_data[7:0] = rxb_r[li[2:0] - 3'h4];
         end else if (li == `CBF_IDX_LEN) begin
            rd_data[`CBF_LEN_CODE_MSB:0] = rx_len_r;
         end else if (li == `CBF_IDX_STAMP_HI) begin
            rd_data[7:0] = rx_stamp_r[15:8];
         end else if (li == `CBF_IDX_STAMP_LO) begin
            rd_data[7:0] = rx_stamp_r[7:0];
         end
      end else if (addr_ok_r) begin
         if (addr_idx_r >= `CBF_IDX_DATA0 && addr_idx_r <= `CBF_IDX_DATA7 && sel_r != 3'h0) begin
            rd_data[7:0] = txb_r[sel_idx][addr_idx_r[2:0] - 3'h4]; // R18
         end else if (addr_idx_r == `CBF_IDX_LEN && sel_r != 3'h0) begin
            rd_data[`CBF_LEN_CODE_MSB:0] = len_r[sel_idx]; // R03
         end else if (addr_idx_r == `CBF_IDX_LOCAL_PRIORITY_VALUE && sel_r != 3'h0) begin
            rd_data[7:0] = local_priority_value_r[sel_idx];
         end else if (addr_idx_r == `CBF_IDX_STAMP_HI && sel_r != 3'h0) begin
            rd_data[7:0] = stamp_r[sel_idx][15:8];
         end else if (addr_idx_r == `CBF_IDX_STAMP_LO && sel_r != 3'h0) begin
            rd_data[7:0] = stamp_r[sel_idx][7:0];
         end else if (addr_idx_r == `CBF_IDX_SELECT) begin
            rd_data[`CBF_NUM_TX-1:0] = sel_r;
         end else if (addr_idx_r == `CBF_IDX_TXFLAG) begin
            rd_data[`CBF_NUM_TX-1:0] = txe_r;
         end else if (addr_idx_r == `CBF_IDX_CTRL) begin
            rd_data[1:0] = ctrl_r;
         end else if (addr_idx_r == `CBF_IDX_REMOTE) begin
            rd_data[`CBF_NUM_TX-1:0] = remote_r;
         end else if (addr_idx_r == `CBF_IDX_STATUS) begin
            rd_data[1:0] = act_r;
            rd_data[`CBF_STAT_ACTIVE_BIT] = tx_frame_active;
            rd_data[`CBF_STAT_TIMER_LSB +: 16] = timer_r;
         end
      end
   end

   // ---------------- control registers ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= `CBF_CTRL_RST;
         remote_r <= 3'h0;
         sel_r <= 3'h0;
      end else if (wr_en) begin
         if (addr_idx_r == `CBF_IDX_CTRL) begin
            ctrl_r <= hwdata[1:0];
         end
         if (addr_idx_r == `CBF_IDX_REMOTE) begin
            remote_r <= hwdata[`CBF_NUM_TX-1:0];
         end
         // lowest requested buffer that is free gets mapped
         if (addr_idx_r == `CBF_IDX_SELECT) begin
            sel_r <= hwdata[`CBF_NUM_TX-1:0] & txe_r & ~((hwdata[`CBF_NUM_TX-1:0] & txe_r) - 3'h1); // R18
         end
      end
   end

   // hardware set wins over a software clear in the same cycle
   always_comb begin
      txe_nxt = txe_r;
      if (wr_en && addr_idx_r == `CBF_IDX_TXFLAG) begin
         txe_nxt = txe_r & ~hwdata[`CBF_NUM_TX-1:0];
      end
      txe_nxt = txe_nxt | done_set; // R17
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         txe_r <= `CBF_TXE_RST;
      end else begin
         txe_r <= txe_nxt;
      end
   end

   // ---------------- per-buffer storage ----------------
   for (genvar b = 0; b < `CBF_NUM_TX; b++) begin : g_buf
      assign done_set[b] = (state_r != CBF_IDLE) && tx_done && act_r == cbf_idx_t'(b);
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            for (int i = 0; i < 8; i++) begin
               txb_r[b][i] <= 8'h00;
            end
            len_r[b] <= 4'h0;
            local_priority_value_r[b] <= `CBF_LOCAL_PRIORITY_VALUE_RST;
         end else if (wr_en && sel_r[b]) begin
            if (addr_idx_r >= `CBF_IDX_DATA0 && addr_idx_r <= `CBF_IDX_DATA7) begin
               txb_r[b][addr_idx_r[2:0] - 3'h4] <= hwdata[7:0]; // R01
            end
            if (addr_idx_r == `CBF_IDX_LEN) begin
               len_r[b] <= hwdata[`CBF_LEN_CODE_MSB:0]; // R03
            end
            if (addr_idx_r == `CBF_IDX_LOCAL_PRIORITY_VALUE && txe_r[b]) begin
               local_priority_value_r[b] <= hwdata[7:0]; // R06 R10
            end
         end
      end
      // stamp bytes have no software write path
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            stamp_r[b] <= 16'h0000;
         end else if (done_set[b] && time_en) begin
            stamp_r[b] <= timer_r; // R12 R16
         end
      end
   end

   // ---------------- stamp timer ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_r <= 16'h0000;
      end else if (init_mode) begin
         timer_r <= 16'h0000; // R15
      end else if (bit_tick) begin
         timer_r <= timer_r + 16'h0001; // R14
      end
   end

   // ---------------- arbitration ----------------
   // walk from the top index down so an equal value at a lower index takes over
   always_comb begin
      win_idx = 2'd0;
      win_found = 1'b0;
      win_local_priority_value = 8'hFF;
      for (int k = `CBF_NUM_TX - 1; k >= 0; k--) begin
         if (!txe_r[k] && (!win_found || local_priority_value_r[k] <= win_local_priority_value)) begin // R07 R08 R09
            win_found = 1'b1;
            win_local_priority_value = local_priority_value_r[k];
            win_idx = cbf_idx_t'(k);
         end
      end
   end

   assign cap_len = (len_r[win_idx] > `CBF_MAX_BYTES) ? `CBF_MAX_BYTES : len_r[win_idx]; // R05 R19

   // ---------------- transmit sequencer ----------------
   assign push = (state_r == CBF_LOAD) && in_ready && (byte_cnt_r < byte_total_r);
   assign flush = init_mode || ((state_r != CBF_IDLE) && (tx_fail || tx_done));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= CBF_IDLE;
         act_r <= 2'd0;
         byte_cnt_r <= 4'h0;
         byte_total_r <= 4'h0;
         tx_frame_active <= 1'b0;
         tx_buf_idx <= 2'd0;
         tx_len_code <= 4'h0;
         tx_remote <= 1'b0;
      end else if (flush) begin
         // a failed frame leaves its buffer pending for the next arbitration
         state_r <= CBF_IDLE;
         tx_frame_active <= 1'b0;
      end else begin
         unique case (state_r)
            CBF_IDLE: begin
               if (tx_sof_req && win_found) begin
                  state_r <= CBF_LOAD;
                  act_r <= win_idx;
                  tx_buf_idx <= win_idx;
                  tx_frame_active <= 1'b1;
                  byte_cnt_r <= 4'h0;
                  byte_total_r <= remote_r[win_idx] ? 4'h0 : cap_len; // R02 R04
                  tx_len_code <= len_r[win_idx]; // R04
                  tx_remote <= remote_r[win_idx];
               end
            end
            CBF_LOAD: begin
               if (push) begin
                  byte_cnt_r <= byte_cnt_r + 4'h1;
               end
               if (byte_cnt_r == byte_total_r) begin
                  state_r <= CBF_WAIT;
               end
            end
            CBF_WAIT: begin
               state_r <= CBF_WAIT;
            end
            default: begin
               state_r <= CBF_IDLE;
            end
         endcase
      end
   end

   // two-entry buffer: head drives the port, skid absorbs a stalled word
   assign in_ready = !skid_v_r;
   assign pop = tx_valid && tx_ready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
         skid_v_r <= 1'b0;
         skid_r <= 8'h00;
      end else if (flush) begin
         tx_valid <= 1'b0;
         skid_v_r <= 1'b0;
      end else if (!tx_valid || pop) begin
         if (skid_v_r) begin
            tx_data <= skid_r;
            tx_valid <= 1'b1;
            skid_v_r <= 1'b0;
         end else begin
            tx_valid <= push;
            tx_data <= txb_r[act_r][byte_cnt_r[2:0]];
         end
      end else if (push) begin
         skid_r <= txb_r[act_r][byte_cnt_r[2:0]];
         skid_v_r <= 1'b1;
      end
   end

   // ---------------- receive buffer ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 8; i++) begin
            rxb_r[i] <= 8'h00;
         end
         rx_cnt_r <= 4'h0;
         rx_len_r <= 4'h0;
         rx_stamp_r <= 16'h0000;
      end else begin
         if (rx_sof) begin
            rx_cnt_r <= 4'h0;
         end else if (rx_byte_valid && rx_cnt_r < `CBF_MAX_BYTES && rx_cnt_r < rx_len_code) begin
            rxb_r[rx_cnt_r[2:0]] <= rx_byte; // R01 R02 R19
            rx_cnt_r <= rx_cnt_r + 4'h1;
         end
         if (rx_eof_ok) begin
            rx_len_r <= rx_len_code;
            if (time_en) begin
               rx_stamp_r <= timer_r; // R12
            end
         end
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   logic beat_lower, beat_tie;
   always_comb begin
      beat_lower = 1'b0;
      beat_tie = 1'b0;
      for (int k = 0; k < `CBF_NUM_TX; k++) begin
         if (!txe_r[k] && local_priority_value_r[k] < local_priority_value_r[win_idx]) begin
            beat_lower = 1'b1;
         end
         if (!txe_r[k] && local_priority_value_r[k] == local_priority_value_r[win_idx] && k < int'(win_idx)) begin
            beat_tie = 1'b1;
         end
      end
   end

   sequence s_start;
      state_r == CBF_IDLE && tx_sof_req && win_found && !init_mode;
   endsequence

   sequence s_sent;
      state_r != CBF_IDLE && tx_done && !init_mode;
   endsequence

   lowest_local_priority_value_a: assert property (s_start |-> !beat_lower) else $error("lower priority value lost"); // R08
   tie_index_a: assert property (s_start |-> !beat_tie) else $error("tie not won by lower index"); // R09
   pick_pending_a: assert property (s_start |=> tx_frame_active && !txe_r[tx_buf_idx]) // R07
      else $error("started buffer not pending");
   remote_empty_a: assert property (tx_frame_active && tx_remote |-> !tx_valid && byte_total_r == 4'h0) // R04
      else $error("remote frame sent data");
   cap_bytes_a: assert property (s_start ##1 1'b1 |-> byte_total_r <= `CBF_MAX_BYTES) // R19
      else $error("more than eight bytes scheduled");
   done_empty_a: assert property (s_sent |=> txe_r[$past(act_r)] && !tx_frame_active) // R17
      else $error("sent buffer not flagged empty");
   stamp_take_a: assert property (s_sent and time_en |=> stamp_r[$past(act_r)] == $past(timer_r)) // R12
      else $error("stamp not captured");
   timer_init_a: assert property (init_mode |=> timer_r == 16'h0000) else $error("timer not cleared"); // R15
   timer_run_a: assert property (!init_mode && bit_tick |=> timer_r == $past(timer_r) + 16'h0001) // R14
      else $error("timer did not advance");
   // same buffer on both sides, so a select change in between cannot fire it
   stamp_ro_a: assert property (!(state_r != CBF_IDLE && tx_done) // R16
      |=> stamp_r[$past(sel_idx)] == $past(stamp_r[sel_idx]))
      else $error("stamp changed without a frame");
endmodule : cbf_buffers

// ### test/cbf_engine_model.sv
module cbf_engine_model (
   // clock
   input wire logic hclk,
   // transmit side
   output logic tx_sof_req,
   output logic tx_done,
   output logic tx_fail,
   input wire logic tx_frame_active,
   input wire cbf_pkg::cbf_idx_t tx_buf_idx,
   input wire cbf_pkg::cbf_len_t tx_len_code,
   input wire logic tx_remote,
   input wire cbf_pkg::cbf_byte_t tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // receive side
   output logic rx_sof,
   output cbf_pkg::cbf_len_t rx_len_code,
   output logic rx_byte_valid,
   output cbf_pkg::cbf_byte_t rx_byte,
   output logic rx_eof_ok,
   // bit time
   output logic bit_tick
);
   import cbf_pkg::*;
   cbf_byte_t got[$];
   cbf_idx_t cap_idx;
   cbf_len_t cap_len;
   logic cap_rem;
   initial begin
      {tx_sof_req, tx_done, tx_fail, rx_sof, rx_byte_valid, rx_eof_ok, bit_tick} = 7'h00;
      tx_ready = 1'b1;
      rx_len_code = 4'h0;
      rx_byte = 8'h00;
   end
   // pulls bytes until the device goes quiet; stall keeps ready low most cycles
   task automatic tx_frame(input bit stall, input bit fail);
      int idle;
      int cyc;
      idle = 0;
      cyc = 0;
      got.delete();
      @(posedge hclk);
      tx_sof_req <= 1'b1;
      @(posedge hclk);
      tx_sof_req <= 1'b0;
      while (idle < 8) begin
         @(posedge hclk);
         cyc++;
         if (tx_frame_active === 1'b1) begin
            cap_idx = tx_buf_idx;
            cap_len = tx_len_code;
            cap_rem = tx_remote;
         end
         if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got.push_back(tx_data);
            idle = 0;
         end else begin
            idle++;
         end
         tx_ready <= !stall || (cyc % 4 == 3);
      end
      if (fail) tx_fail <= 1'b1;
      else tx_done <= 1'b1;
      @(posedge hclk);
      tx_fail <= 1'b0;
      tx_done <= 1'b0;
      tx_ready <= 1'b1;
      repeat (2) @(posedge hclk);
   endtask : tx_frame
   task automatic rx_frame(input cbf_len_t len, input int n, input cbf_byte_t base);
      @(posedge hclk);
      rx_sof <= 1'b1;
      rx_len_code <= len;
      @(posedge hclk);
      rx_sof <= 1'b0;
      for (int i = 0; i < n; i++) begin
         rx_byte_valid <= 1'b1;
         rx_byte <= base + 8'(i);
         @(posedge hclk);
      end
      rx_byte_valid <= 1'b0;
      // released data line must not look like a held byte
      rx_byte <= ~rx_byte;
      rx_eof_ok <= 1'b1;
      @(posedge hclk);
      rx_eof_ok <= 1'b0;
   endtask : rx_frame
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge hclk);
         bit_tick <= 1'b1;
         @(posedge hclk);
         bit_tick <= 1'b0;
      end
   endtask : ticks
endmodule : cbf_engine_model

// ### test/tb_top.sv
`include "cbf_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import cbf_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic tx_sof_req, tx_done, tx_fail, tx_frame_active, tx_remote, tx_valid, tx_ready;
   logic rx_sof, rx_byte_valid, rx_eof_ok, bit_tick;
   cbf_idx_t tx_buf_idx;
   cbf_len_t tx_len_code, rx_len_code;
   cbf_byte_t tx_data, rx_byte;
   int errors = 0;
   int checked = 0;
   cbf_buffers uut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .tx_sof_req, .tx_done, .tx_fail, .tx_frame_active, .tx_buf_idx,
      .tx_len_code, .tx_remote, .tx_data, .tx_valid, .tx_ready, .rx_sof, .rx_len_code,
      .rx_byte_valid, .rx_byte, .rx_eof_ok, .bit_tick
   );
   cbf_engine_model eng (
      .hclk, .tx_sof_req, .tx_done, .tx_fail, .tx_frame_active, .tx_buf_idx, .tx_len_code,
      .tx_remote, .tx_data, .tx_valid, .tx_ready, .rx_sof, .rx_len_code, .rx_byte_valid,
      .rx_byte, .rx_eof_ok, .bit_tick
   );
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // no cycle limit here: a stuck slave is caught by the watchdog
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
      rdv = hrdata;
      chk(32'(hresp), 32'h0);
   endtask : bus
   task automatic wr(input logic [5:0] i, input logic [31:0] d);
      bus(1'b1, {24'h0, i, 2'b00}, d);
   endtask : wr
   task automatic rd(input logic [5:0] i, input logic [31:0] e);
      bus(1'b0, {24'h0, i, 2'b00}, 32'h0);
      chk(rdv, e);
   endtask : rd
   task automatic chk_frame(input logic [31:0] idx, input logic [31:0] len, input logic [31:0] n);
      chk(32'(eng.cap_idx), idx);
      chk(32'(eng.cap_len), len);
      chk(32'(eng.got.size()), n);
      foreach (eng.got[k])
         chk(32'(eng.got[k]), (idx << 4) + 32'(k));
   endtask : chk_frame
   task automatic t_regs();
      rd(`CBF_IDX_TXFLAG, 32'h7);
      rd(`CBF_IDX_CTRL, 32'h1);
      wr(`CBF_IDX_SELECT, 32'h2);
      rd(`CBF_IDX_SELECT, 32'h2);
      rd(`CBF_IDX_LOCAL_PRIORITY_VALUE, 32'h0);
      wr(`CBF_IDX_STAMP_HI, 32'hAB);
      wr(`CBF_IDX_STAMP_LO, 32'hCD);
      rd(`CBF_IDX_STAMP_HI, 32'h0);
      rd(`CBF_IDX_STAMP_LO, 32'h0);
      bus(1'b1, 32'h41, 32'h1);
      rd(`CBF_IDX_SELECT, 32'h2);
      rd(6'h3F, 32'h0);
      eng.ticks(5);
      rd(`CBF_IDX_STATUS, 32'h0);
   endtask : t_regs
   // fill all three buffers while empty; buffer 2 gets an oversize code
   task automatic t_load();
      for (int b = 0; b < 3; b++) begin
         wr(`CBF_IDX_SELECT, 32'h1 << b);
         for (int i = 0; i < 8; i++)
            wr(`CBF_IDX_DATA0 + 6'(i), 32'(b * 16 + i));
         wr(`CBF_IDX_LEN, (b == 0) ? 32'h8 : (b == 1) ? 32'h0 : 32'hFC);
         wr(`CBF_IDX_LOCAL_PRIORITY_VALUE, (b == 0) ? 32'h5 : 32'h3);
      end
      for (int i = 0; i < 8; i++)
         rd(`CBF_IDX_DATA0 + 6'(i), 32'h20 + 32'(i));
      rd(`CBF_IDX_LEN, 32'hC);
      rd(`CBF_IDX_LOCAL_PRIORITY_VALUE, 32'h3);
   endtask : t_load
   task automatic t_arb();
      wr(`CBF_IDX_CTRL, 32'h0);
      wr(`CBF_IDX_TXFLAG, 32'h7);
      eng.tx_frame(1'b0, 1'b0);
      chk_frame(32'h1, 32'h0, 32'h0);
      eng.tx_frame(1'b1, 1'b0);
      chk_frame(32'h2, 32'hC, 32'h8);
      rd(`CBF_IDX_TXFLAG, 32'h6);
      eng.tx_frame(1'b0, 1'b1);
      rd(`CBF_IDX_TXFLAG, 32'h6);
      eng.tx_frame(1'b1, 1'b0);
      chk_frame(32'h0, 32'h8, 32'h8);
      rd(`CBF_IDX_TXFLAG, 32'h7);
   endtask : t_arb
   task automatic t_remote();
      wr(`CBF_IDX_SELECT, 32'h1);
      wr(`CBF_IDX_LEN, 32'h5);
      wr(`CBF_IDX_REMOTE, 32'h1);
      wr(`CBF_IDX_TXFLAG, 32'h1);
      eng.tx_frame(1'b0, 1'b0);
      chk_frame(32'h0, 32'h5, 32'h0);
      chk(32'(eng.cap_rem), 32'h1);
      wr(`CBF_IDX_REMOTE, 32'h0);
   endtask : t_remote
   // ticks are stopped during frames so the stamp is known exactly
   task automatic t_stamp();
      wr(`CBF_IDX_CTRL, 32'h2);
      wr(`CBF_IDX_SELECT, 32'h2);
      wr(`CBF_IDX_LEN, 32'h1);
      eng.ticks(7);
      wr(`CBF_IDX_TXFLAG, 32'h2);
      eng.tx_frame(1'b0, 1'b0);
      rd(`CBF_IDX_TXFLAG, 32'h7);
      wr(`CBF_IDX_SELECT, 32'h2);
      rd(`CBF_IDX_STAMP_HI, 32'h0);
      rd(`CBF_IDX_STAMP_LO, 32'h7);
      eng.ticks(300);
      eng.rx_frame(4'hA, 10, 8'h70);
      for (int i = 0; i < 8; i++)
         rd(`CBF_IDX_RX_BASE + 6'h04 + 6'(i), 32'h70 + 32'(i));
      rd(`CBF_IDX_RX_BASE + 6'h0C, 32'hA);
      rd(`CBF_IDX_RX_BASE + 6'h0E, 32'h1);
      rd(`CBF_IDX_RX_BASE + 6'h0F, 32'h33);
      wr(`CBF_IDX_CTRL, 32'h1);
      eng.ticks(3);
      bus(1'b0, {24'h0, `CBF_IDX_STATUS, 2'b00}, 32'h0);
      chk(rdv >> 16, 32'h0);
   endtask : t_stamp
   task automatic tally_and_finish();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (20000) @(posedge hclk);
      errors++;
      tally_and_finish();
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_load();
      t_arb();
      t_remote();
      t_stamp();
      tally_and_finish();
   end
endmodule : tb_top
